/* mgo_pkg.sv */
`default_nettype none
package mgo_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned XADDR_W = 16;
	localparam int unsigned SADDR_W = 8;
	localparam int unsigned NUM_GROUPS = 3;
	// memory-mapped control register offsets
	localparam logic [15:0] OFF_GRP_I_DIR = 16'h7FA6;
	localparam logic [15:0] OFF_GRP_I_LVL = 16'h7FA7;
	localparam logic [15:0] OFF_GRP_I_OUT = 16'h7FA8;
	localparam logic [15:0] OFF_OWNER_SEL = 16'h7FA9;
	localparam logic [15:0] OFF_GRP_H_BUF = 16'h7FAA;
	localparam logic [15:0] OFF_GRP_I_BUF = 16'h7FAB;
	localparam logic [15:0] OFF_MISC_BUF = 16'h7FAC;
	localparam logic [15:0] OFF_PORT_J_DIR = 16'h7FAD;
	localparam logic [15:0] OFF_PORT_K_DIR = 16'h7FAE;
	// special-function register addresses
	localparam logic [7:0] SFR_PORT_J = 8'h80;
	localparam logic [7:0] SFR_PORT_K = 8'h90;
	// writable field masks and reset values
	localparam logic [7:0] OWNER_SEL_MASK = 8'h07;
	localparam logic [7:0] MISC_BUF_MASK = 8'h03;
	localparam logic [7:0] REG_RESET = 8'h00;
	// owner select and misc buffer field positions
	localparam int unsigned OWN_BIT_G = 0;
	localparam int unsigned OWN_BIT_H = 1;
	localparam int unsigned OWN_BIT_I = 2;
	localparam int unsigned MISC_BIT_AUX_ZERO = 0;
	localparam int unsigned MISC_BIT_AUX_PIN7 = 1;
	typedef enum logic [1:0] {SFR_OP_WRITE, SFR_OP_SET_BIT, SFR_OP_CLR_BIT, SFR_OP_NONE} mgo_sfr_op_t;
endpackage
`default_nettype wire

/* mgo_pin_drive.sv */
`timescale 1ns/1ps
`default_nettype none
// registered pin driver: selects owner, applies buffer type
module mgo_pin_drive #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hostOwn,
	input wire logic [WIDTH-1:0] mcuDir,
	input wire logic [WIDTH-1:0] mcuOut,
	input wire logic [WIDTH-1:0] hostDir,
	input wire logic [WIDTH-1:0] hostOut,
	input wire logic [WIDTH-1:0] openDrain,
	output logic [WIDTH-1:0] pinOut,
	output logic [WIDTH-1:0] pinOe
);
	import mgo_pkg::*;
	if (WIDTH < 1) begin : g_bad_width
		$error("mgo_pin_drive: WIDTH must be at least 1");
	end
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic selDir;
			logic selOut;
			assign selDir = hostOwn ? hostDir[gi] : mcuDir[gi];
			assign selOut = hostOwn ? hostOut[gi] : mcuOut[gi];
			// open-drain drives only low; push-pull drives both levels
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					pinOut[gi] <= 1'b0;
					pinOe[gi] <= 1'b0;
				end else begin
					pinOut[gi] <= selOut;
					pinOe[gi] <= selDir & (~openDrain[gi] | ~selOut);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* mgo_gpio_groups.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Group I has eight pins; register bit n drives pin n.
// R02: Group I direction register: one is output; resets to zero.
// R03: Group I level register is read-only and returns live pin levels.
// R04: Group I output latch holds driven levels; resets to zero.
// R05: Owner bits 0..2 map to groups G, H, I; bits 3..7 read zero.
// R06: Owner bit one hands that group's pins to host settings.
// R07: Owner bit zero gives microcontroller control; all owned at reset.
// R08: Register access from both sides is unaffected by owner bits.
// R09: Firmware sets owner bit before host enables its pin device; the test raises hostActive before it writes the owner bits.
// R10: Groups H and I buffer bits: one open-drain, zero push-pull.
// R11: Misc buffer register bits 0,1 pick pin buffer type; rest read zero.
// R12: Two bit-addressable ports serve pins thirty-x and forty-x.
// R13: Bit set and clear instructions address register address plus bit.
// R14: Port write updates latch; reads of input bits return pins.
// R15: Two direction registers control the two bit-addressable ports.
// R16: Port direction registers memory-mapped, reset zero, one means output.
// R17: All writable registers return to defaults on standby reset.
module mgo_gpio_groups #(
	parameter int unsigned PIN_W = mgo_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic xWrEn,
	input wire logic xRdEn,
	input wire logic [mgo_pkg::XADDR_W-1:0] xAddr,
	input wire logic [PIN_W-1:0] xWrData,
	output logic [PIN_W-1:0] xRdData,
	input wire logic sfrWrEn,
	input wire logic sfrBitWrEn,
	input wire logic sfrRdEn,
	input wire logic [mgo_pkg::SADDR_W-1:0] sfrAddr,
	input wire logic [PIN_W-1:0] sfrWrData,
	input wire logic sfrBitVal,
	output logic [PIN_W-1:0] sfrRdData,
	input wire logic [PIN_W-1:0] hostDirG,
	input wire logic [PIN_W-1:0] hostOutG,
	input wire logic [PIN_W-1:0] hostDirH,
	input wire logic [PIN_W-1:0] hostOutH,
	input wire logic [PIN_W-1:0] hostDirI,
	input wire logic [PIN_W-1:0] hostOutI,
	input wire logic [PIN_W-1:0] mcuDirG,
	input wire logic [PIN_W-1:0] mcuOutG,
	input wire logic [PIN_W-1:0] mcuDirH,
	input wire logic [PIN_W-1:0] mcuOutH,
	output logic [2:0] groupOwnerBit,
	output logic [PIN_W-1:0] sharedHostPinGOut,
	output logic [PIN_W-1:0] sharedHostPinGOe,
	output logic [PIN_W-1:0] sharedHostPinHOut,
	output logic [PIN_W-1:0] sharedHostPinHOe,
	input wire logic [PIN_W-1:0] sharedHostPinIIn,
	output logic [PIN_W-1:0] sharedHostPinIOut,
	output logic [PIN_W-1:0] sharedHostPinIOe,
	input wire logic auxOutputZeroLevel,
	input wire logic auxPinSevenLevel,
	input wire logic auxPinSevenDir,
	output logic auxOutputZeroOut,
	output logic auxOutputZeroOe,
	output logic auxPinSevenOut,
	output logic auxPinSevenOe,
	input wire logic [PIN_W-1:0] bitPortPinJIn,
	output logic [PIN_W-1:0] bitPortPinJOut,
	output logic [PIN_W-1:0] bitPortPinJOe,
	input wire logic [PIN_W-1:0] bitPortPinKIn,
	output logic [PIN_W-1:0] bitPortPinKOut,
	output logic [PIN_W-1:0] bitPortPinKOe
);
	import mgo_pkg::*;
	if (PIN_W != DATA_W) begin : g_bad_width
		$error("mgo_gpio_groups: PIN_W must equal DATA_W");
	end

	logic [PIN_W-1:0] groupIDirection;
	logic [PIN_W-1:0] groupIOutputLatch;
	logic [PIN_W-1:0] groupHBufferType;
	logic [PIN_W-1:0] groupIBufferType;
	logic [1:0] miscPinBufferType;
	logic [PIN_W-1:0] portJData;
	logic [PIN_W-1:0] portKData;
	logic [PIN_W-1:0] portJDirection;
	logic [PIN_W-1:0] portKDirection;
	logic [PIN_W-1:0] next_xRdData;
	logic [PIN_W-1:0] next_sfrRdData;
	mgo_sfr_op_t sfrOp;
	logic [2:0] sfrBitIdx;

	function automatic logic xHit(input logic [XADDR_W-1:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	// which port a byte or bit address falls in; bit address = base + index
	function automatic logic sfrHit(input logic [SADDR_W-1:0] a, input logic [7:0] base,
		input logic isBit);
		return isBit ? (a[7:3] == base[7:3]) : (a == base);
	endfunction

	// byte write or bit set/clear update of a port latch
	function automatic logic [7:0] portUpdate(input logic [7:0] cur, input mgo_sfr_op_t op,
		input logic [2:0] idx, input logic [7:0] wd);
		logic [7:0] r;
		r = cur;
		case (op)
			SFR_OP_WRITE: r = wd;
			SFR_OP_SET_BIT: r[idx] = 1'b1;
			SFR_OP_CLR_BIT: r[idx] = 1'b0;
			default: r = cur;
		endcase
		return r;
	endfunction

	// read value: output latch where driven, pin level where input
	function automatic logic [7:0] portRead(input logic [7:0] lat, input logic [7:0] dir,
		input logic [7:0] pins);
		return (lat & dir) | (pins & ~dir);
	endfunction

	assign sfrBitIdx = sfrAddr[2:0];
	always_comb begin
		if (sfrWrEn) begin
			sfrOp = SFR_OP_WRITE;
		end else if (sfrBitWrEn) begin
			sfrOp = sfrBitVal ? SFR_OP_SET_BIT : SFR_OP_CLR_BIT; // [R13]
		end else begin
			sfrOp = SFR_OP_NONE;
		end
	end

	// memory-mapped registers, all default to zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			groupIDirection <= REG_RESET; // [R02] [R17]
			groupIOutputLatch <= REG_RESET; // [R04] [R17]
		end else if (xWrEn) begin
			if (xHit(xAddr, OFF_GRP_I_DIR)) groupIDirection <= xWrData; // [R02]
			if (xHit(xAddr, OFF_GRP_I_OUT)) groupIOutputLatch <= xWrData; // [R04]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			groupOwnerBit <= 3'h0; // [R07] [R17]
		end else if (xWrEn && xHit(xAddr, OFF_OWNER_SEL)) begin
			groupOwnerBit <= xWrData[2:0]; // [R05]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			groupHBufferType <= REG_RESET; // [R10] [R17]
			groupIBufferType <= REG_RESET; // [R10] [R17]
			miscPinBufferType <= 2'h0; // [R11] [R17]
		end else if (xWrEn) begin
			if (xHit(xAddr, OFF_GRP_H_BUF)) groupHBufferType <= xWrData; // [R10]
			if (xHit(xAddr, OFF_GRP_I_BUF)) groupIBufferType <= xWrData; // [R10]
			if (xHit(xAddr, OFF_MISC_BUF)) miscPinBufferType <= xWrData[1:0]; // [R11]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			portJDirection <= REG_RESET; // [R16] [R17]
			portKDirection <= REG_RESET; // [R16] [R17]
		end else if (xWrEn) begin
			if (xHit(xAddr, OFF_PORT_J_DIR)) portJDirection <= xWrData; // [R15] [R16]
			if (xHit(xAddr, OFF_PORT_K_DIR)) portKDirection <= xWrData; // [R15] [R16]
		end
	end

	// bit-addressable port latches
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			portJData <= REG_RESET; // [R14] [R17]
			portKData <= REG_RESET; // [R14] [R17]
		end else begin
			if (sfrHit(sfrAddr, SFR_PORT_J, sfrBitWrEn && !sfrWrEn)) begin
				portJData <= portUpdate(portJData, sfrOp, sfrBitIdx, sfrWrData); // [R12] [R13]
			end
			if (sfrHit(sfrAddr, SFR_PORT_K, sfrBitWrEn && !sfrWrEn)) begin
				portKData <= portUpdate(portKData, sfrOp, sfrBitIdx, sfrWrData); // [R12] [R13]
			end
		end
	end

	// reads are independent of ownership
	always_comb begin
		next_xRdData = '0;
		case (xAddr)
			OFF_GRP_I_DIR: next_xRdData = groupIDirection;
			OFF_GRP_I_LVL: next_xRdData = sharedHostPinIIn; // [R03] [R01]
			OFF_GRP_I_OUT: next_xRdData = groupIOutputLatch;
			OFF_OWNER_SEL: next_xRdData = {5'h00, groupOwnerBit}; // [R05] [R08]
			OFF_GRP_H_BUF: next_xRdData = groupHBufferType;
			OFF_GRP_I_BUF: next_xRdData = groupIBufferType;
			OFF_MISC_BUF: next_xRdData = {6'h00, miscPinBufferType}; // [R11]
			OFF_PORT_J_DIR: next_xRdData = portJDirection;
			OFF_PORT_K_DIR: next_xRdData = portKDirection;
			default: next_xRdData = '0;
		endcase
	end

	always_comb begin
		next_sfrRdData = '0;
		if (sfrAddr == SFR_PORT_J) begin
			next_sfrRdData = portRead(portJData, portJDirection, bitPortPinJIn); // [R14]
		end else if (sfrAddr == SFR_PORT_K) begin
			next_sfrRdData = portRead(portKData, portKDirection, bitPortPinKIn); // [R14]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xRdData <= '0;
			sfrRdData <= '0;
		end else begin
			if (xRdEn) xRdData <= next_xRdData; // [R08]
			if (sfrRdEn) sfrRdData <= next_sfrRdData;
		end
	end

	// group pin drivers; group G has no buffer-type control
	mgo_pin_drive #(.WIDTH(PIN_W)) u_drive_g (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(groupOwnerBit[OWN_BIT_G]), // [R06] [R07]
		.mcuDir(mcuDirG),
		.mcuOut(mcuOutG),
		.hostDir(hostDirG),
		.hostOut(hostOutG),
		.openDrain('0),
		.pinOut(sharedHostPinGOut),
		.pinOe(sharedHostPinGOe)
	);
	mgo_pin_drive #(.WIDTH(PIN_W)) u_drive_h (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(groupOwnerBit[OWN_BIT_H]), // [R06] [R07]
		.mcuDir(mcuDirH),
		.mcuOut(mcuOutH),
		.hostDir(hostDirH),
		.hostOut(hostOutH),
		.openDrain(groupHBufferType), // [R10]
		.pinOut(sharedHostPinHOut),
		.pinOe(sharedHostPinHOe)
	);
	mgo_pin_drive #(.WIDTH(PIN_W)) u_drive_i (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(groupOwnerBit[OWN_BIT_I]), // [R06] [R07]
		.mcuDir(groupIDirection), // [R01] [R02]
		.mcuOut(groupIOutputLatch), // [R04]
		.hostDir(hostDirI),
		.hostOut(hostOutI),
		.openDrain(groupIBufferType), // [R10]
		.pinOut(sharedHostPinIOut),
		.pinOe(sharedHostPinIOe)
	);
	mgo_pin_drive #(.WIDTH(PIN_W)) u_drive_j (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(1'b0),
		.mcuDir(portJDirection), // [R16]
		.mcuOut(portJData),
		.hostDir('0),
		.hostOut('0),
		.openDrain('0),
		.pinOut(bitPortPinJOut),
		.pinOe(bitPortPinJOe)
	);
	mgo_pin_drive #(.WIDTH(PIN_W)) u_drive_k (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(1'b0),
		.mcuDir(portKDirection), // [R16]
		.mcuOut(portKData),
		.hostDir('0),
		.hostOut('0),
		.openDrain('0),
		.pinOut(bitPortPinKOut),
		.pinOe(bitPortPinKOe)
	);
	// aux pins: level from core logic, buffer type from misc register
	mgo_pin_drive #(.WIDTH(2)) u_drive_aux (
		.clk(clk),
		.rst_b(rst_b),
		.hostOwn(1'b0),
		.mcuDir({auxPinSevenDir, 1'b1}),
		.mcuOut({auxPinSevenLevel, auxOutputZeroLevel}),
		.hostDir('0),
		.hostOut('0),
		.openDrain(miscPinBufferType), // [R11]
		.pinOut({auxPinSevenOut, auxOutputZeroOut}),
		.pinOe({auxPinSevenOe, auxOutputZeroOe})
	);

	a_owner_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
		xRdEn && xAddr == OFF_OWNER_SEL |=> xRdData[7:3] == 5'h00) // [R05]
		else $error("owner select reserved bits not zero");
	a_owner_write_takes: assert property (@(posedge clk) disable iff (!rst_b)
		xWrEn && xAddr == OFF_OWNER_SEL |=> groupOwnerBit == $past(xWrData[2:0])) // [R05]
		else $error("owner select write lost");
	a_host_drives_i: assert property (@(posedge clk) disable iff (!rst_b)
		groupOwnerBit[OWN_BIT_I] && $stable(groupOwnerBit) && !groupIBufferType[0]
		|=> sharedHostPinIOe[0] == $past(hostDirI[0])) // [R06]
		else $error("host ownership not applied to group I");
	a_mcu_drives_i: assert property (@(posedge clk) disable iff (!rst_b)
		!groupOwnerBit[OWN_BIT_I] && !groupIBufferType[3]
		|=> sharedHostPinIOut[3] == $past(groupIOutputLatch[3])
		&& sharedHostPinIOe[3] == $past(groupIDirection[3])) // [R07] [R04]
		else $error("microcontroller control of group I wrong");
	a_level_read_live: assert property (@(posedge clk) disable iff (!rst_b)
		xRdEn && xAddr == OFF_GRP_I_LVL |=> xRdData == $past(sharedHostPinIIn)) // [R03]
		else $error("group I level read wrong");
	a_dir_readback: assert property (@(posedge clk) disable iff (!rst_b)
		xWrEn && xAddr == OFF_GRP_I_DIR ##1 !xWrEn
		##1 xRdEn && xAddr == OFF_GRP_I_DIR && !xWrEn
		|=> xRdData == $past(xWrData, 3)) // [R02] [R08]
		else $error("group I direction readback wrong");
	a_open_drain_high: assert property (@(posedge clk) disable iff (!rst_b)
		groupHBufferType[2] && (groupOwnerBit[OWN_BIT_H] ? hostOutH[2] : mcuOutH[2])
		|=> !sharedHostPinHOe[2]) // [R10]
		else $error("open-drain pin drove high");
	a_bit_set_port: assert property (@(posedge clk) disable iff (!rst_b)
		sfrBitWrEn && !sfrWrEn && sfrBitVal && sfrAddr == (SFR_PORT_J | 8'h07)
		|=> portJData[7]) // [R13] [R12]
		else $error("bit set on port J failed");
	a_bit_clr_port: assert property (@(posedge clk) disable iff (!rst_b)
		sfrBitWrEn && !sfrWrEn && !sfrBitVal && sfrAddr == (SFR_PORT_K | 8'h01)
		|=> !portKData[1] && portKData[0] == $past(portKData[0])
		&& portKData[7:2] == $past(portKData[7:2])) // [R13]
		else $error("bit clear on port K wrong");
	a_port_read_input: assert property (@(posedge clk) disable iff (!rst_b)
		sfrRdEn && sfrAddr == SFR_PORT_J && !portJDirection[0]
		|=> sfrRdData[0] == $past(bitPortPinJIn[0])) // [R14] [R15]
		else $error("port J input bit read wrong");
	a_misc_reserved: assert property (@(posedge clk) disable iff (!rst_b)
		xRdEn && xAddr == OFF_MISC_BUF |=> xRdData[7:2] == 6'h00) // [R11]
		else $error("misc buffer reserved bits not zero");

	c_host_takes_i: cover property (@(posedge clk) disable iff (!rst_b)
		!groupOwnerBit[OWN_BIT_I] ##1 groupOwnerBit[OWN_BIT_I]);
	c_bit_set: cover property (@(posedge clk) disable iff (!rst_b)
		sfrBitWrEn && sfrBitVal && sfrAddr[7:3] == SFR_PORT_K[7:3]);
	c_open_drain_low: cover property (@(posedge clk) disable iff (!rst_b)
		groupIBufferType[0] && sharedHostPinIOe[0]);
endmodule
`default_nettype wire

/* mgo_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module mgo_far_side (
	input wire logic hostActive,
	input wire logic [7:0] extI,
	input wire logic [7:0] extJ,
	input wire logic [7:0] extK,
	input wire logic [7:0] pinIOut,
	input wire logic [7:0] pinIOe,
	input wire logic [7:0] pinJOut,
	input wire logic [7:0] pinJOe,
	input wire logic [7:0] pinKOut,
	input wire logic [7:0] pinKOe,
	output logic [7:0] hostDirG,
	output logic [7:0] hostOutG,
	output logic [7:0] hostDirH,
	output logic [7:0] hostOutH,
	output logic [7:0] hostDirI,
	output logic [7:0] hostOutI,
	output logic [7:0] levelI,
	output logic [7:0] levelJ,
	output logic [7:0] levelK
);
	// host settings appear only once the host pin device is switched on
	assign hostDirG = hostActive ? 8'h96 : 8'h00;
	assign hostOutG = hostActive ? 8'h0F : 8'h00;
	assign hostDirH = hostActive ? 8'h69 : 8'h00;
	assign hostOutH = hostActive ? 8'hF0 : 8'h00;
	assign hostDirI = hostActive ? 8'hC3 : 8'h00;
	assign hostOutI = hostActive ? 8'h55 : 8'h00;
	// undriven pins show the level of the external circuit
	assign levelI = (pinIOe & pinIOut) | (~pinIOe & extI);
	assign levelJ = (pinJOe & pinJOut) | (~pinJOe & extJ);
	assign levelK = (pinKOe & pinKOut) | (~pinKOe & extK);
endmodule
`default_nettype wire

/* mgo_gpio_groups_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mgo_gpio_groups_test;
	import mgo_pkg::*;
	logic clk, rst_b, xWrEn, xRdEn, sfrWrEn, sfrBitWrEn, sfrRdEn, sfrBitVal, hostActive;
	logic auxZLvl, auxSLvl, auxSDir, auxZOut, auxZOe, auxSOut, auxSOe;
	logic [15:0] xAddr;
	logic [7:0] xWrData, xRdData, sfrAddr, sfrWrData, sfrRdData, extI, extJ, extK;
	logic [7:0] hostDirG, hostOutG, hostDirH, hostOutH, hostDirI, hostOutI;
	logic [7:0] mcuDirG, mcuOutG, mcuDirH, mcuOutH, levelI, levelJ, levelK;
	logic [7:0] gOut, gOe, hOut, hOe, iOut, iOe, jOut, jOe, kOut, kOe;
	logic [2:0] groupOwnerBit;
	int nFail, checks;
	logic [15:0] addrs [9] = '{16'h7FA6, 16'h7FA8, 16'h7FA9, 16'h7FAA, 16'h7FAB,
		16'h7FAC, 16'h7FAD, 16'h7FAE, 16'h7FB0};
	logic [7:0] full [9] = '{8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h00};

	mgo_gpio_groups i_mgo_gpio_groups (.clk(clk), .rst_b(rst_b), .xWrEn(xWrEn), .xRdEn(xRdEn),
		.xAddr(xAddr), .xWrData(xWrData), .xRdData(xRdData), .sfrWrEn(sfrWrEn),
		.sfrBitWrEn(sfrBitWrEn), .sfrRdEn(sfrRdEn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrBitVal(sfrBitVal), .sfrRdData(sfrRdData), .hostDirG(hostDirG), .hostOutG(hostOutG),
		.hostDirH(hostDirH), .hostOutH(hostOutH), .hostDirI(hostDirI), .hostOutI(hostOutI),
		.mcuDirG(mcuDirG), .mcuOutG(mcuOutG), .mcuDirH(mcuDirH), .mcuOutH(mcuOutH),
		.groupOwnerBit(groupOwnerBit), .sharedHostPinGOut(gOut), .sharedHostPinGOe(gOe),
		.sharedHostPinHOut(hOut), .sharedHostPinHOe(hOe), .sharedHostPinIIn(levelI),
		.sharedHostPinIOut(iOut), .sharedHostPinIOe(iOe), .auxOutputZeroLevel(auxZLvl),
		.auxPinSevenLevel(auxSLvl), .auxPinSevenDir(auxSDir), .auxOutputZeroOut(auxZOut),
		.auxOutputZeroOe(auxZOe), .auxPinSevenOut(auxSOut), .auxPinSevenOe(auxSOe),
		.bitPortPinJIn(levelJ), .bitPortPinJOut(jOut), .bitPortPinJOe(jOe),
		.bitPortPinKIn(levelK), .bitPortPinKOut(kOut), .bitPortPinKOe(kOe));

	mgo_far_side i_mgo_far_side (.hostActive(hostActive), .extI(extI), .extJ(extJ),
		.extK(extK), .pinIOut(iOut), .pinIOe(iOe), .pinJOut(jOut), .pinJOe(jOe),
		.pinKOut(kOut), .pinKOe(kOe), .hostDirG(hostDirG), .hostOutG(hostOutG),
		.hostDirH(hostDirH), .hostOutH(hostOutH), .hostDirI(hostDirI), .hostOutI(hostOutI),
		.levelI(levelI), .levelJ(levelJ), .levelK(levelK));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xAddr = a;
		xWrData = d;
		xWrEn = 1'b1;
		cyc(1);
		xWrEn = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		xAddr = a;
		xRdEn = 1'b1;
		cyc(1);
		xRdEn = 1'b0;
		cyc(1);
		chk(xRdData, e);
	endtask

	task automatic sfw(input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		cyc(1);
		sfrWrEn = 1'b0;
		cyc(1);
	endtask

	task automatic sfb(input logic [7:0] a, input logic v);
		sfrAddr = a;
		sfrBitVal = v;
		sfrBitWrEn = 1'b1;
		cyc(1);
		sfrBitWrEn = 1'b0;
		cyc(1);
	endtask

	task automatic special_function_register(input logic [7:0] a, input logic [7:0] e);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		cyc(1);
		sfrRdEn = 1'b0;
		cyc(1);
		chk(sfrRdData, e);
	endtask

	initial begin
		#400000;
		nFail++;
		conclude();
	end

	initial begin
		{xWrEn, xRdEn, sfrWrEn, sfrBitWrEn, sfrRdEn, sfrBitVal, hostActive} = '0;
		{auxZLvl, auxSLvl, auxSDir} = '0;
		{xAddr, xWrData, sfrAddr, sfrWrData} = '0;
		{mcuDirG, mcuOutG, mcuDirH, mcuOutH} = '0;
		extI = 8'h5A;
		extJ = 8'h00;
		extK = 8'hA0;
		rst_b = 1'b0;
		cyc(10);
		rst_b = 1'b1;
		cyc(1);
		for (int i = 0; i < 9; i++) rd(addrs[i], 8'h00);
		for (int i = 0; i < 9; i++) wr(addrs[i], 8'hFF);
		wr(16'h7FA7, 8'h00);
		for (int i = 0; i < 9; i++) rd(addrs[i], full[i]);
		chk({5'h00, groupOwnerBit}, 8'h07);
		for (int i = 0; i < 9; i++) wr(addrs[i], 8'h00);
		rd(16'h7FA7, 8'h5A);
		mcuDirG = 8'hF0;
		mcuOutG = 8'h30;
		wr(16'h7FA6, 8'hA5);
		wr(16'h7FA8, 8'h3C);
		cyc(2);
		chk(iOe, 8'hA5);
		chk(iOut & 8'hA5, 8'h24);
		chk(gOe, 8'hF0);
		chk(gOut, 8'h30);
		rd(16'h7FA7, 8'h7E);
		hostActive = 1'b1;
		wr(16'h7FA9, 8'h07);
		cyc(2);
		chk(iOe, 8'hC3);
		chk(iOut & 8'hC3, 8'h41);
		chk(gOe, 8'h96);
		chk(hOe, 8'h69);
		chk(gOut, 8'h0F);
		chk(hOut, 8'hF0);
		rd(16'h7FA6, 8'hA5);
		rd(16'h7FA7, 8'h59);
		wr(16'h7FA9, 8'h00);
		mcuDirH = 8'hFF;
		mcuOutH = 8'h0F;
		wr(16'h7FAA, 8'hFF);
		wr(16'h7FAB, 8'hFF);
		cyc(2);
		chk(hOe, 8'hF0);
		chk(hOut, 8'h0F);
		chk(iOe, 8'h81);
		auxZLvl = 1'b1;
		cyc(3);
		chk({6'h00, auxZOe, auxZOut}, 8'h03);
		wr(16'h7FAC, 8'h03);
		auxSDir = 1'b1;
		cyc(2);
		chk({6'h00, auxZOe, auxSOe}, 8'h01);
		auxZLvl = 1'b0;
		auxSLvl = 1'b1;
		cyc(3);
		chk({6'h00, auxZOe, auxSOe}, 8'h02);
		chk({6'h00, auxSOut, auxZOut}, 8'h02);
		wr(16'h7FAD, 8'hFF);
		sfw(SFR_PORT_J, 8'h0F);
		cyc(2);
		chk(jOut, 8'h0F);
		chk(jOe, 8'hFF);
		sfb(8'h87, 1'b1);
		special_function_register(SFR_PORT_J, 8'h8F);
		sfb(8'h80, 1'b0);
		special_function_register(SFR_PORT_J, 8'h8E);
		special_function_register(SFR_PORT_K, 8'hA0);
		sfw(SFR_PORT_K, 8'hC3);
		wr(16'h7FAE, 8'h0F);
		cyc(2);
		chk(kOe, 8'h0F);
		chk(kOut, 8'hC3);
		special_function_register(SFR_PORT_K, 8'hA3);
		sfb(8'h91, 1'b0);
		special_function_register(SFR_PORT_K, 8'hA1);
		rst_b = 1'b0;
		cyc(3);
		rst_b = 1'b1;
		cyc(1);
		rd(16'h7FAD, 8'h00);
		rd(16'h7FA6, 8'h00);
		special_function_register(SFR_PORT_J, 8'h00);
		wr(16'h7FA6, 8'h96);
		rd(16'h7FA6, 8'h96);
		conclude();
	end
endmodule
`default_nettype wire
